// *** ccp_unit.sv ***
// Purpose: capture, compare and pwm unit with an apb register slave
// Assumes: timer counts come from timers outside this block
// Notes:   register bytes sit in prdata[7:0], upper bits read zero
//
// What this block does
// RULE_01 - four capture prescales; counter cleared when off
// RULE_02 - prescale switch keeps counter, may flag
// RULE_03 - compare value against timer one continuously
// RULE_04 - match drives high, low, toggles or leaves pin
// RULE_05 - flag set with the pin action
// RULE_06 - control write of zero clears compare latch
// RULE_07 - software sets pin output, synchronous timer one
// RULE_08 - mode 1010 only raises the flag
// RULE_09 - mode 1011 pulses timer one reset
// RULE_10 - that pulse starts conversion if converter enabled
// RULE_11 - pwm mode drives pin, period from timer two
// RULE_12 - period end sets pin unless duty is zero, loads buffered duty
// RULE_13 - timer two postscaler ignored for pwm
// RULE_14 - duty is low byte then control bits five:four
// RULE_15 - duty takes effect next period; high read-only
// RULE_16 - duty double-buffered in high byte plus latch
// RULE_17 - pin clears when duty equals extended count
// RULE_18 - duty above period never clears pin
// RULE_19 - high time is duty times tick time
// RULE_20 - software sets pwm up in fixed order
// RULE_21 - capture copies timer one, flags, overwrites
// RULE_22 - modes 0100..0111 pick the capture event
// RULE_23 - toggle, set and clear compare modes
// RULE_24 - mode 0000 resets unit; 11xx is pwm
// RULE_25 - pin input synchronised before edge detection
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ccp_unit
	import ccp_pkg::*;
#(
	parameter int unsigned TIMER_W = 16
)(
	// clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic     [31:0]         prdata,
	output logic                    pready,
	output logic                    pslverr,
	// timer one
	input  wire logic [TIMER_W-1:0] timer_one_count,
	output logic                    timer_one_reset,
	// timer two
	input  wire logic [7:0]         timer_two_count,
	input  wire logic [1:0]         timer_two_phase,
	input  wire logic [7:0]         timer_two_period,
	input  wire logic               timer_two_inc,
	// converter
	input  wire logic               adc_enabled,
	output logic                    adc_start,
	// unit pin and port
	input  wire logic               unit_pin_in,
	input  wire logic               port_c_bit_two,
	input  wire logic               pin_direction_bit,
	output logic                    unit_pin_out,
	output logic                    unit_pin_oe,
	// event flag
	output logic                    unit_event_flag,
	output logic                    unit_irq
);
	if (TIMER_W != 16) begin : g_width_check
		$error("timer width must be 16");
	end

	logic [7:0]  unit_value_low;
	logic [7:0]  unit_value_high;
	logic [7:0]  unit_control;
	logic        unit_event_irq_enable;
	logic [1:0]  duty_latch;
	logic        cmp_latch;
	logic        pwm_latch;
	logic        eq_q;
	logic        cap_ev;
	logic        cmp_hit;
	logic        period_end;
	logic        period_end_q;
	logic        wr;
	logic        rd_cycle;
	logic        mapped;
	logic [3:0]  unit_mode_field;
	logic [1:0]  duty_low_bits;
	logic [9:0]  next_duty;
	unit_class_e cls;

	assign unit_mode_field = unit_control[3:0];
	assign duty_low_bits   = unit_control[CTL_DUTY_LSB+1:CTL_DUTY_LSB];
	assign cls             = mode_class(unit_mode_field);
	assign next_duty       = {unit_value_low, duty_low_bits}; // RULE_14
	assign mapped          = paddr == OFF_VALUE_LOW || paddr == OFF_VALUE_HIGH ||
	                         paddr == OFF_CONTROL || paddr == OFF_STATUS;
	// access phase ends one wait state in; write lands at that edge
	assign rd_cycle   = psel & penable & ~pready;
	assign wr         = psel & penable & pready & pwrite;
	assign cmp_hit    = cls == CLS_COMPARE && !eq_q &&
	                    {unit_value_high, unit_value_low} == timer_one_count; // RULE_03
	// the postscaler never reaches this block
	assign period_end = timer_two_inc && timer_two_count == timer_two_period; // RULE_12 RULE_13

	// capture event source
	capture_event_detect u_detect (
		.pclk        (pclk),
		.presetn     (presetn),
		.pin_in      (unit_pin_in),
		.mode        (unit_mode_field),
		.active      (cls == CLS_CAPTURE), // RULE_01 RULE_24
		.event_pulse (cap_ev)
	);

	// apb handshake and read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= rd_cycle;
			pslverr <= rd_cycle & ~mapped;
			prdata  <= 32'h0000_0000;
			if (rd_cycle && !pwrite) begin
				case (paddr)
					OFF_VALUE_LOW:  prdata[7:0] <= unit_value_low;
					OFF_VALUE_HIGH: prdata[7:0] <= unit_value_high;
					OFF_CONTROL:    prdata[7:0] <= unit_control;
					OFF_STATUS: begin
						prdata[STAT_FLAG_BIT] <= unit_event_flag;
						prdata[STAT_IE_BIT]   <= unit_event_irq_enable;
					end
					default:        prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// control register and irq enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_control          <= RESET_BYTE;
			unit_event_irq_enable <= 1'b0;
		end else if (wr && paddr == OFF_CONTROL) begin
			unit_control <= pwdata[7:0] & CTL_MASK;
		end else if (wr && paddr == OFF_STATUS) begin
			unit_event_irq_enable <= pwdata[STAT_IE_BIT];
		end
	end

	// value low byte: capture beats a software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_value_low <= RESET_BYTE;
		end else if (cap_ev) begin
			unit_value_low <= timer_one_count[7:0]; // RULE_21
		end else if (wr && paddr == OFF_VALUE_LOW) begin
			unit_value_low <= pwdata[7:0]; // RULE_15
		end
	end

	// value high byte: duty buffer in pwm, read-only there
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_value_high <= RESET_BYTE;
			duty_latch      <= 2'b00;
		end else if (cls == CLS_PWM) begin
			if (period_end) begin
				unit_value_high <= unit_value_low; // RULE_16
				duty_latch      <= duty_low_bits;
			end
		end else if (cap_ev) begin
			unit_value_high <= timer_one_count[15:8]; // RULE_21
		end else if (wr && paddr == OFF_VALUE_HIGH) begin
			unit_value_high <= pwdata[7:0]; // RULE_15
		end
	end

	// equality history so a stalled timer matches once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eq_q <= 1'b0;
		end else begin
			eq_q <= {unit_value_high, unit_value_low} == timer_one_count;
		end
	end

	// compare output latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_latch <= 1'b0;
		end else if (wr && paddr == OFF_CONTROL) begin
			if (pwdata[7:0] == RESET_BYTE) begin
				cmp_latch <= 1'b0; // RULE_06
			end else if (pwdata[3:0] == MODE_SET) begin
				cmp_latch <= 1'b0; // RULE_23
			end else if (pwdata[3:0] == MODE_CLEAR) begin
				cmp_latch <= 1'b1; // RULE_23
			end
		end else if (cmp_hit) begin
			case (unit_mode_field)
				MODE_TOGGLE: cmp_latch <= ~cmp_latch; // RULE_04
				MODE_SET:    cmp_latch <= 1'b1;
				MODE_CLEAR:  cmp_latch <= 1'b0;
				default:     cmp_latch <= cmp_latch; // RULE_08
			endcase
		end
	end

	// period end seen one cycle late, so the set and the registered clear
	// lag alike and the high time is exactly the duty in timer ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_end_q <= 1'b0;
		end else begin
			period_end_q <= period_end && cls == CLS_PWM; // RULE_12 RULE_19
		end
	end

	// pwm output latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_latch <= 1'b0;
		end else if (cls != CLS_PWM) begin
			pwm_latch <= 1'b0; // RULE_24
		end else if (period_end_q) begin
			pwm_latch <= {unit_value_high, duty_latch} != 10'h000; // RULE_12
		end else if ({unit_value_high, duty_latch} ==
		             {timer_two_count, timer_two_phase}) begin
			pwm_latch <= 1'b0; // RULE_17 RULE_18 RULE_19
		end
	end

	// pin mux and direction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_pin_out <= 1'b0;
			unit_pin_oe  <= 1'b0;
		end else begin
			unit_pin_oe <= ~pin_direction_bit;
			case (cls)
				CLS_PWM:     unit_pin_out <= pwm_latch; // RULE_11
				CLS_COMPARE: unit_pin_out <= (unit_mode_field == MODE_SOFT) ?
				                             port_c_bit_two : cmp_latch; // RULE_08
				default:     unit_pin_out <= port_c_bit_two;
			endcase
		end
	end

	// event flag: hardware set wins over write-one-to-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_event_flag <= 1'b0;
		end else if (cap_ev || cmp_hit) begin
			unit_event_flag <= 1'b1; // RULE_05 RULE_21
		end else if (wr && paddr == OFF_STATUS && pwdata[STAT_FLAG_BIT]) begin
			unit_event_flag <= 1'b0;
		end
	end

	// irq, special event and converter start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_irq        <= 1'b0;
			timer_one_reset <= 1'b0;
			adc_start       <= 1'b0;
		end else begin
			unit_irq        <= unit_event_flag & unit_event_irq_enable; // RULE_08
			timer_one_reset <= cmp_hit && unit_mode_field == MODE_SPECIAL; // RULE_09
			adc_start       <= cmp_hit && unit_mode_field == MODE_SPECIAL &&
			                   adc_enabled; // RULE_10
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// capture and compare checks
	a_capture_load : assert property (cap_ev |=> // RULE_21
		{unit_value_high, unit_value_low} == $past(timer_one_count))
		else $error("capture did not load timer one");
	a_capture_flag : assert property (cap_ev |=> unit_event_flag) // RULE_21
		else $error("capture did not set flag");
	a_match_flag : assert property (cmp_hit |=> unit_event_flag) // RULE_05
		else $error("match did not set flag");
	a_set_action : assert property (cmp_hit && unit_mode_field == MODE_SET && // RULE_04
		!wr |=> cmp_latch ##1 unit_pin_out)
		else $error("set mode did not drive pin high");
	a_toggle_action : assert property (cmp_hit && unit_mode_field == MODE_TOGGLE && // RULE_23
		!wr |=> cmp_latch != $past(cmp_latch))
		else $error("toggle mode did not toggle");
	a_soft_pin : assert property (cls == CLS_COMPARE && unit_mode_field == MODE_SOFT // RULE_08
		|=> unit_pin_out == $past(port_c_bit_two))
		else $error("software mode pin does not follow port latch");
	a_irq_follow : assert property (unit_event_flag && unit_event_irq_enable |=> // RULE_08
		unit_irq)
		else $error("enabled flag did not raise irq");
	a_special_pulse : assert property (cmp_hit && unit_mode_field == MODE_SPECIAL // RULE_09
		|=> timer_one_reset && (adc_start == $past(adc_enabled)))
		else $error("special event pulse wrong");
	a_special_only : assert property (timer_one_reset |-> // RULE_09
		$past(cmp_hit) && $past(unit_mode_field) == MODE_SPECIAL)
		else $error("timer one reset without special match");
	a_adc_gate : assert property (adc_start |-> timer_one_reset) // RULE_10
		else $error("conversion start without special event");
	a_adc_enabled : assert property (adc_start |-> $past(adc_enabled)) // RULE_10
		else $error("conversion start with converter disabled");
	a_zero_control : assert property (wr && paddr == OFF_CONTROL && // RULE_06
		pwdata[7:0] == RESET_BYTE |=> !cmp_latch ##1 (unit_pin_out == $past(port_c_bit_two)))
		else $error("zero control did not clear latch");
	// pwm and register checks
	a_duty_load : assert property (cls == CLS_PWM && period_end |=> // RULE_16
		{unit_value_high, duty_latch} == $past(next_duty))
		else $error("duty not loaded at period end");
	a_pwm_set : assert property (cls == CLS_PWM && period_end_q |=> // RULE_12
		pwm_latch == ($past(unit_value_high) != 8'h00 || $past(duty_latch) != 2'b00))
		else $error("pwm pin not set at period end");
	a_pwm_clear : assert property (cls == CLS_PWM && !period_end_q && // RULE_17
		{unit_value_high, duty_latch} == {timer_two_count, timer_two_phase} |=> !pwm_latch)
		else $error("pwm pin not cleared at duty match");
	a_pwm_off : assert property (cls != CLS_PWM |=> !pwm_latch) // RULE_24
		else $error("pwm latch set outside pwm mode");
	a_high_readonly : assert property (cls == CLS_PWM && !period_end |=> // RULE_15
		$stable(unit_value_high))
		else $error("high byte changed in pwm mode");
	a_high_write : assert property (cls != CLS_PWM && !cap_ev && wr && // RULE_15
		paddr == OFF_VALUE_HIGH |=>
		{24'h00_0000, unit_value_high} == ($past(pwdata) & 32'h0000_00ff))
		else $error("high byte write lost outside pwm mode");
	a_apb_answer : assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");
	a_apb_unmapped : assert property (psel && penable && !pready && !mapped |=> pslverr)
		else $error("unmapped access without error");

	c_capture : cover property (cap_ev ##1 unit_event_flag);
	c_match_irq : cover property (cmp_hit ##2 unit_irq);
	c_special : cover property (adc_start);
	c_pwm_cycle : cover property (pwm_latch ##[1:1000] !pwm_latch);
	c_flag_clear : cover property (unit_event_flag ##1 !unit_event_flag);
endmodule : ccp_unit
`default_nettype wire

// *** ccp_pkg.sv ***
// Purpose: shared constants for the capture/compare/pwm unit
// Assumes: 8-bit register contents in the low lane of a 32-bit apb word
// Notes:   offsets are byte addresses
package ccp_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_VALUE_LOW  = 8'h00;
	localparam logic [7:0] OFF_VALUE_HIGH = 8'h04;
	localparam logic [7:0] OFF_CONTROL    = 8'h08;
	localparam logic [7:0] OFF_STATUS     = 8'h0c;
	// control and status fields
	localparam int unsigned CTL_DUTY_LSB  = 4;
	localparam logic [7:0]  CTL_MASK      = 8'h3f;
	localparam int unsigned STAT_FLAG_BIT = 0;
	localparam int unsigned STAT_IE_BIT   = 1;
	localparam logic [7:0]  RESET_BYTE    = 8'h00;
	// mode field encodings
	localparam logic [3:0] MODE_OFF     = 4'h0;
	localparam logic [3:0] MODE_TOGGLE  = 4'h2;
	localparam logic [3:0] MODE_CAP_FE  = 4'h4;
	localparam logic [3:0] MODE_CAP_RE  = 4'h5;
	localparam logic [3:0] MODE_CAP_4   = 4'h6;
	localparam logic [3:0] MODE_CAP_16  = 4'h7;
	localparam logic [3:0] MODE_SET     = 4'h8;
	localparam logic [3:0] MODE_CLEAR   = 4'h9;
	localparam logic [3:0] MODE_SOFT    = 4'ha;
	localparam logic [3:0] MODE_SPECIAL = 4'hb;
	// capture prescale terminal counts
	localparam logic [3:0] PRE_LAST_1  = 4'h0;
	localparam logic [3:0] PRE_LAST_4  = 4'h3;
	localparam logic [3:0] PRE_LAST_16 = 4'hf;
	// operating class of the unit
	typedef enum logic [1:0] {
		CLS_OFF     = 2'b00,
		CLS_CAPTURE = 2'b01,
		CLS_COMPARE = 2'b10,
		CLS_PWM     = 2'b11
	} unit_class_e;
	// mode field to operating class
	function automatic unit_class_e mode_class(input logic [3:0] m);
		if (m[3:2] == 2'b11) begin
			return CLS_PWM;
		end else if (m[3:2] == 2'b01) begin
			return CLS_CAPTURE;
		end else if (m[3] || m == MODE_TOGGLE) begin
			return CLS_COMPARE;
		end
		return CLS_OFF;
	endfunction : mode_class
endpackage : ccp_pkg

// *** capture_event_detect.sv ***
// Purpose: synchronise the unit pin and pick capture events
// Assumes: pin_in is asynchronous to pclk
// Notes:   event_pulse is one cycle wide
`timescale 1ns/1ps
`default_nettype none
module capture_event_detect
	import ccp_pkg::*;
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// pin and mode
	input  wire logic       pin_in,
	input  wire logic [3:0] mode,
	input  wire logic       active,
	// event out
	output logic            event_pulse
);
	logic       sync_a;
	logic       sync_b;
	logic       prev;
	logic [3:0] cnt;
	logic [3:0] last;
	logic       rise;
	logic       fall;

	// two-flop synchroniser then edge history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			prev   <= 1'b0;
		end else begin
			sync_a <= pin_in; // RULE_25
			sync_b <= sync_a;
			prev   <= sync_b;
		end
	end

	assign rise = sync_b & ~prev;
	assign fall = ~sync_b & prev;

	// terminal count per prescale choice
	always_comb begin
		case (mode)
			MODE_CAP_4:  last = PRE_LAST_4; // RULE_22
			MODE_CAP_16: last = PRE_LAST_16;
			default:     last = PRE_LAST_1;
		endcase
	end

	// prescale counter, kept across prescale switches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
		end else if (!active) begin
			cnt <= 4'h0; // RULE_01
		end else if (rise && mode != MODE_CAP_FE) begin
			cnt <= (cnt >= last) ? 4'h0 : cnt + 4'h1; // RULE_02
		end
	end

	// event selection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_pulse <= 1'b0;
		end else if (mode == MODE_CAP_FE) begin
			event_pulse <= active & fall; // RULE_22
		end else begin
			event_pulse <= active & rise & (cnt >= last);
		end
	end

	a_prescale_idle : assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
		!active |=> cnt == 4'h0)
		else $error("prescale counter not cleared while inactive");
endmodule : capture_event_detect
`default_nettype wire

// *** pin_partner.sv ***
// Purpose: signal source and load on the unit pin
// Assumes: the unit wins the wire whenever its enable is high
// Notes:   the source drives only while the unit releases the pin
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
	// level the source wants on the pin
	input  wire logic drive_level,
	// unit side of the pin
	input  wire logic unit_pin_out,
	input  wire logic unit_pin_oe,
	output logic      unit_pin_in
);
	// resolved wire level fed back to the unit
	assign unit_pin_in = unit_pin_oe ? unit_pin_out : drive_level;
endmodule : pin_partner
`default_nettype wire

// *** capture_compare_pwm_unit_test.sv ***
// Purpose: self-checking bench for the capture/compare/pwm unit
// Assumes: one wait state apb slave, register byte in the low lane
// Notes:   timer one and timer two are modelled here
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module capture_compare_pwm_unit_test;
	import ccp_pkg::*;
	logic        pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, tper = 8'hff, tcount = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [15:0] t1 = 16'h0, v;
	logic [1:0]  tphase = 2'h0;
	logic [3:0]  m;
	logic        pready, pslverr, t1_rst, adc_start, pin_in, pin_out, pin_oe, flag, irq, tinc;
	logic        adc_en = 1'b0, drv = 1'b0, pc = 1'b0, pin_dir = 1'b1, timer_two_count_on = 1'b0;
	logic        idle, exp_pin;
	logic [3:0]  cm [6] = '{MODE_SET, MODE_TOGGLE, MODE_CLEAR, MODE_SOFT, MODE_SPECIAL,
		MODE_SPECIAL};
	int          dl [5] = '{0, 0, 19, 20, 27};
	int          compares = 0, miscompares = 0, rst_cnt = 0, adc_cnt = 0;
	int          n, r0, a0, d, hi;
	int          exp_q [$];

	ccp_unit #(.TIMER_W(16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_one_count(t1),
		.timer_one_reset(t1_rst), .timer_two_count(tcount), .timer_two_phase(tphase),
		.timer_two_period(tper), .timer_two_inc(tinc), .adc_enabled(adc_en),
		.adc_start(adc_start), .unit_pin_in(pin_in), .port_c_bit_two(pc),
		.pin_direction_bit(pin_dir), .unit_pin_out(pin_out), .unit_pin_oe(pin_oe),
		.unit_event_flag(flag), .unit_irq(irq));
	pin_partner pin (.drive_level(drv), .unit_pin_out(pin_out), .unit_pin_oe(pin_oe),
		.unit_pin_in(pin_in));

	// clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// timer two: one phase tick per clock, count wraps at the period
	assign tinc = timer_two_count_on && tphase == 2'h3;
	always @(posedge pclk) begin
		tphase <= timer_two_count_on ? tphase + 2'h1 : 2'h0;
		if (!timer_two_count_on) tcount <= 8'h00;
		else if (tphase == 2'h3) tcount <= (tcount == tper) ? 8'h00 : tcount + 8'h01;
		if (t1_rst === 1'b1) rst_cnt <= rst_cnt + 1;
		if (adc_start === 1'b1) adc_cnt <= adc_cnt + 1;
	end

	task automatic results();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results

	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd,
		output logic [7:0] rd, output logic err);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			miscompares++;
			results();
		end
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [7:0] wd);
		logic [7:0] r;
		logic       e;
		apb(1'b1, a, wd, r, e);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic ee);
		logic [7:0] r;
		logic       er;
		apb(1'b0, a, 8'h00, r, er);
		`CHK(r, e)
		`CHK(er, ee)
	endtask : rdc

	task automatic pulse();
		drv <= ~drv;
		repeat (3) @(posedge pclk);
		drv <= ~drv;
		repeat (3) @(posedge pclk);
	endtask : pulse

	task automatic wait_flag();
		int k;
		k = 0;
		while (flag !== 1'b1 && k < 12) begin
			@(posedge pclk);
			k++;
		end
		if (k >= 12) begin
			miscompares++;
			results();
		end
	endtask : wait_flag

	// main sequence: registers, capture, compare, pwm
	initial begin
		void'($urandom(3));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 4; i++) rdc(8'(i * 4), RESET_BYTE, 1'b0);
		rdc(8'h10, 8'h00, 1'b1);
		for (int i = 0; i < 4; i++) begin
			m = MODE_CAP_FE + 4'(i);
			n = (i < 2) ? 1 : ((i == 2) ? 4 : 16);
			idle = (i == 0);
			wr(OFF_CONTROL, 8'h00);
			wr(OFF_STATUS, 8'h03);
			drv <= idle;
			v = 16'($urandom);
			exp_q.push_back(int'(v));
			t1 <= v;
			repeat (4) @(posedge pclk);
			wr(OFF_CONTROL, {4'h0, m});
			repeat (n - 1) pulse();
			repeat (6) @(posedge pclk);
			`CHK(flag, 1'b0)
			pulse();
			wait_flag();
			rdc(OFF_VALUE_LOW, 8'(exp_q[0]), 1'b0);
			rdc(OFF_VALUE_HIGH, 8'(exp_q.pop_front() >> 8), 1'b0);
		end
		wr(OFF_CONTROL, {4'h0, MODE_CAP_4});
		repeat (3) pulse();
		wr(OFF_CONTROL, 8'h00);
		wr(OFF_STATUS, 8'h03);
		wr(OFF_CONTROL, {4'h0, MODE_CAP_4});
		repeat (2) pulse();
		repeat (6) @(posedge pclk);
		`CHK(flag, 1'b0)
		for (int i = 0; i < 6; i++) begin
			m = cm[i];
			wr(OFF_CONTROL, 8'h00);
			wr(OFF_STATUS, 8'h03);
			repeat (2) @(posedge pclk);
			pin_dir <= 1'b0;
			pc <= 1'($urandom);
			adc_en <= (i == 4);
			v = 16'($urandom);
			t1 <= v + 16'h0005;
			wr(OFF_VALUE_LOW, v[7:0]);
			wr(OFF_VALUE_HIGH, v[15:8]);
			wr(OFF_CONTROL, {4'h0, m});
			repeat (3) @(posedge pclk);
			if (m == MODE_SET || m == MODE_CLEAR) `CHK(pin_out, m[0])
			if (m == MODE_TOGGLE) `CHK(pin_out, 1'b0)
			`CHK(flag, 1'b0)
			r0 = rst_cnt;
			a0 = adc_cnt;
			t1 <= v;
			repeat (4) @(posedge pclk);
			t1 <= v + 16'h0001;
			exp_pin = (m == MODE_SOFT) ? pc : ((m == MODE_CLEAR) ? 1'b0 : 1'b1);
			if (m != MODE_SPECIAL) `CHK(pin_out, exp_pin)
			`CHK(flag, 1'b1)
			`CHK(irq, 1'b1)
			`CHK(rst_cnt - r0, (m == MODE_SPECIAL) ? 1 : 0)
			`CHK(adc_cnt - a0, (i == 4) ? 1 : 0)
		end
		wr(OFF_CONTROL, 8'h00);
		tper <= 8'h04;
		pin_dir <= 1'b0;
		timer_two_count_on <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			d = (i == 1) ? int'($urandom_range(18, 1)) : dl[i];
			wr(OFF_VALUE_LOW, 8'(d >> 2));
			wr(OFF_CONTROL, {2'b00, 2'(d), 2'b11, 2'(i)});
			repeat (60) @(posedge pclk);
			rdc(OFF_VALUE_HIGH, 8'(d >> 2), 1'b0);
			wr(OFF_VALUE_HIGH, 8'h5a);
			rdc(OFF_VALUE_HIGH, 8'(d >> 2), 1'b0);
			hi = 0;
			repeat (40) begin
				@(posedge pclk);
				hi += int'(pin_out === 1'b1);
			end
			`CHK(hi, 2 * ((d > 20) ? 20 : d))
		end
		results();
	end
endmodule : capture_compare_pwm_unit_test
`default_nettype wire
